// *** logic/fst_system_timer.sv ***
// System timer: 56-bit free-running counter behind an AHB-Lite slave
`timescale 1ns/1ns
`default_nettype none
`include "fst_regs.svh"

module fst_system_timer
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic appResetReq,
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic irq,
   output logic serviceRequest0,
   output logic serviceRequest1
);

   // ***************************************************
   // Register state
   // ***************************************************
   logic [55:0] count;
   logic [23:0] highCapture;
   logic [31:0] compareValue0;
   logic [31:0] compareValue1;
   fst_pkg::fst_cmp_field_t cmpField0;
   fst_pkg::fst_cmp_field_t cmpField1;
   fst_pkg::fst_clock_ctrl_t clockCtrl;
   logic appResetDisable;
   logic [1:0] irqStatus;
   logic [1:0] irqMask;
   logic halfPhase;
   logic appSync1;
   logic appSync2;
   fst_pkg::fst_bus_state_t busState;
   logic [11:0] dataAddr;
   logic dataWrite;

   // ***************************************************
   // Bus decode
   // ***************************************************
   wire logic addrPhase;
   wire logic isWindow;
   wire logic [2:0] windowIdx;
   wire logic [55:0] windowShift;
   wire logic [31:0] windowValue;
   wire logic lowWindowRead;
   wire logic writeNow;
   wire logic [31:0] readMux;
   wire logic tick;
   wire logic appClear;
   wire logic match0;
   wire logic match1;
   wire logic [31:0] cmpCtrlValue;
   wire logic [11:0] windowOffset;

   assign addrPhase = hsel && hready && htrans[1];
   assign windowOffset = haddr - `FST_OFF_WINDOW_0;
   assign isWindow = (haddr >= `FST_OFF_WINDOW_0) && (haddr <= `FST_OFF_WINDOW_6)
      && (haddr[1:0] == 2'h0);
   assign windowIdx = windowOffset[4:2];
   // Window n shows bits 4n+31..4n; window six shows 55..32
   assign windowShift = (windowIdx == 3'h6) ? (count >> `FST_HIGH_LSB)
      : (count >> ({3'h0, windowIdx} * 6'(`FST_WINDOW_STEP)));
   assign windowValue = windowShift[31:0];
   assign lowWindowRead = addrPhase && !hwrite && isWindow && (windowIdx != 3'h6);
   assign writeNow = (busState == fst_pkg::FST_DATA) && dataWrite;
   assign cmpCtrlValue = {3'h0, cmpField1.sizeMinusOne, 3'h0, cmpField1.startBit,
      3'h0, cmpField0.sizeMinusOne, 3'h0, cmpField0.startBit};

   assign readMux =
      isWindow ? windowValue :
      (haddr == `FST_OFF_CLOCK_CONTROL) ? {29'h0, clockCtrl.divideByTwo,
         clockCtrl.suspend, clockCtrl.timerOff} :
      (haddr == `FST_OFF_CAPTURE) ? {8'h00, highCapture} :
      (haddr == `FST_OFF_COMPARE_0) ? compareValue0 :
      (haddr == `FST_OFF_COMPARE_1) ? compareValue1 :
      (haddr == `FST_OFF_COMPARE_CONTROL) ? cmpCtrlValue :
      (haddr == `FST_OFF_IRQ_STATUS) ? {30'h0, irqStatus} :
      (haddr == `FST_OFF_IRQ_MASK) ? {30'h0, irqMask} :
      (haddr == `FST_OFF_APP_RESET) ? {31'h0, appResetDisable} :
      32'h0000_0000;

   // ***************************************************
   // Timer clock and application reset
   // ***************************************************
   // Off or suspend stops the count; divide-by-two out of reset
   assign tick = !clockCtrl.timerOff && !clockCtrl.suspend
      && (!clockCtrl.divideByTwo || halfPhase);
   assign appClear = appSync2 && !appResetDisable;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         appSync1 <= 1'b0;
         appSync2 <= 1'b0;
         halfPhase <= 1'b0;
      end
      else
      begin
         appSync1 <= appResetReq;
         appSync2 <= appSync1;
         halfPhase <= !halfPhase;
      end
   end

   // Counter runs from reset with no enable write; wraps naturally
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         count <= 56'h0;
      end
      else if (appClear)
      begin
         count <= 56'h0;
      end
      else if (tick)
      begin
         count <= count + 56'h1;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         highCapture <= 24'h0;
      end
      else if (lowWindowRead)
      begin
         highCapture <= count[55:32];
      end
      else if (appClear)
      begin
         highCapture <= 24'h0;
      end
   end

   // ***************************************************
   // Software registers
   // ***************************************************
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         compareValue0 <= 32'h0;
         compareValue1 <= 32'h0;
         cmpField0 <= 10'(`FST_CMPC_RESET);
         cmpField1 <= 10'(`FST_CMPC_RESET >> `FST_CMPC_SECOND);
         appResetDisable <= 1'b0;
         irqMask <= 2'h0;
      end
      else if (appClear)
      begin
         compareValue0 <= 32'h0;
         compareValue1 <= 32'h0;
         cmpField0 <= 10'(`FST_CMPC_RESET);
         cmpField1 <= 10'(`FST_CMPC_RESET >> `FST_CMPC_SECOND);
         irqMask <= 2'h0;
      end
      else if (writeNow)
      begin
         if (dataAddr == `FST_OFF_COMPARE_0)
            compareValue0 <= hwdata;
         if (dataAddr == `FST_OFF_COMPARE_1)
            compareValue1 <= hwdata;
         if (dataAddr == `FST_OFF_COMPARE_CONTROL)
         begin
            cmpField0 <= {hwdata[12:8], hwdata[4:0]};
            cmpField1 <= {hwdata[28:24], hwdata[20:16]};
         end
         if (dataAddr == `FST_OFF_APP_RESET)
            appResetDisable <= hwdata[0];
         if (dataAddr == `FST_OFF_IRQ_MASK)
            irqMask <= hwdata[1:0];
      end
   end

   // Clock control is outside the application-reset group
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         clockCtrl <= 3'(`FST_CLC_RESET);
      end
      else if (writeNow && (dataAddr == `FST_OFF_CLOCK_CONTROL))
      begin
         clockCtrl <= {hwdata[`FST_CLC_DIV_BIT], hwdata[`FST_CLC_SUSPEND_BIT],
            hwdata[`FST_CLC_OFF_BIT]};
      end
   end

   // ***************************************************
   // Compare channels and service requests
   // ***************************************************
   fst_compare_unit u_cmp0
   (
      .clk(clk),
      .resetn(resetn),
      .count(count),
      .compareValue(compareValue0),
      .field(cmpField0),
      .match(match0)
   );

   fst_compare_unit u_cmp1
   (
      .clk(clk),
      .resetn(resetn),
      .count(count),
      .compareValue(compareValue1),
      .field(cmpField1),
      .match(match1)
   );

   wire logic [1:0] clearBits;
   assign clearBits = (writeNow && (dataAddr == `FST_OFF_IRQ_STATUS)) ? hwdata[1:0] : 2'h0;

   // Set wins over write-one-to-clear; not touched by application reset
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         irqStatus <= 2'h0;
         irq <= 1'b0;
         serviceRequest0 <= 1'b0;
         serviceRequest1 <= 1'b0;
      end
      else
      begin
         irqStatus <= (irqStatus & ~clearBits) | {match1, match0};
         irq <= |(irqStatus & irqMask);
         serviceRequest0 <= match0;
         serviceRequest1 <= match1;
      end
   end

   // ***************************************************
   // AHB-Lite slave
   // ***************************************************
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         busState <= fst_pkg::FST_IDLE;
         dataAddr <= 12'h0;
         dataWrite <= 1'b0;
         hrdata <= 32'h0;
      end
      else
      begin
         case (busState)
            fst_pkg::FST_IDLE:
            begin
               if (addrPhase)
               begin
                  busState <= fst_pkg::FST_DATA;
                  dataAddr <= haddr;
                  dataWrite <= hwrite;
                  hrdata <= hwrite ? 32'h0 : readMux;
               end
            end
            fst_pkg::FST_DATA:
            begin
               if (addrPhase)
               begin
                  dataAddr <= haddr;
                  dataWrite <= hwrite;
                  hrdata <= hwrite ? 32'h0 : readMux;
               end
               else
               begin
                  busState <= fst_pkg::FST_IDLE;
                  dataWrite <= 1'b0;
               end
            end
            default:
            begin
               busState <= fst_pkg::FST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ***************************************************
   // Checks
   // ***************************************************
   // A write to clock control may legally change the rate at once
   wire logic clockWrite;
   assign clockWrite = writeNow && (dataAddr == `FST_OFF_CLOCK_CONTROL);

   a_count_runs: assert property (@(posedge clk) disable iff (!resetn)
      (tick && !appClear) |=> count == $past(count) + 56'h1)
      else $error("count did not advance");
   a_count_stops: assert property (@(posedge clk) disable iff (!resetn)
      (clockCtrl.suspend && !appClear) |=> count == $past(count))
      else $error("count moved while suspended");
   a_off_holds: assert property (@(posedge clk) disable iff (!resetn)
      (clockCtrl.timerOff && !appClear) |=> $stable(count))
      else $error("count moved while off");
   a_capture_high: assert property (@(posedge clk) disable iff (!resetn)
      lowWindowRead |=> highCapture == $past(count[55:32]))
      else $error("capture missed high part");
   a_app_clear: assert property (@(posedge clk) disable iff (!resetn)
      appClear |=> count == 56'h0)
      else $error("application reset did not clear");
   a_app_keep: assert property (@(posedge clk) disable iff (!resetn)
      (appSync2 && appResetDisable && tick) |=> count != 56'h0 || $past(count) == {56{1'b1}})
      else $error("disabled application reset cleared");
   a_wrap_zero: assert property (@(posedge clk) disable iff (!resetn)
      (count == {56{1'b1}} && tick && !appClear) |=> count == 56'h0)
      else $error("counter did not wrap");
   a_half_rate: assert property (@(posedge clk) disable iff (!resetn)
      (clockCtrl.divideByTwo && tick && !clockWrite) |=> !tick)
      else $error("divided clock ticked twice");
   a_match_request: assert property (@(posedge clk) disable iff (!resetn)
      match0 |=> serviceRequest0 && irqStatus[0])
      else $error("match gave no service request");
   c_low_read: cover property (@(posedge clk) disable iff (!resetn) lowWindowRead);
   c_match1: cover property (@(posedge clk) disable iff (!resetn) match1);
   c_irq: cover property (@(posedge clk) disable iff (!resetn) irq);
   c_suspend: cover property (@(posedge clk) disable iff (!resetn) clockCtrl.suspend);

endmodule // fst_system_timer

`default_nettype wire

// *** inc/fst_regs.svh ***
// Register map, field positions and reset values of the system timer
// Summary of operation
// - 56-bit count increments every timer clock
// - Counting starts by itself after reset
// - App reset clears count, compare and mask registers unless disabled, and capture except in a cycle with a low window read
// - Timer clock from system clock, default half
// - Suspend stops counting, registers stay readable
// - Software can switch timer off
// - Low window read latches high part
// - Seven read-only 32-bit count windows
// - Two compare registers checked continuously
// - Compare uses selectable partial counter field
// - Compare match raises service request
`ifndef FST_REGS_SVH
`define FST_REGS_SVH

`define FST_OFF_CLOCK_CONTROL 12'h000
`define FST_OFF_WINDOW_0 12'h010
`define FST_OFF_WINDOW_6 12'h028
`define FST_OFF_CAPTURE 12'h02c
`define FST_OFF_COMPARE_0 12'h030
`define FST_OFF_COMPARE_1 12'h034
`define FST_OFF_COMPARE_CONTROL 12'h038
`define FST_OFF_IRQ_STATUS 12'h040
`define FST_OFF_IRQ_MASK 12'h044
`define FST_OFF_APP_RESET 12'h048

// Clock control fields
`define FST_CLC_OFF_BIT 0
`define FST_CLC_SUSPEND_BIT 1
`define FST_CLC_DIV_BIT 2
`define FST_CLC_RESET 32'h0000_0004

// Compare control: per compare, start bit [4:0] and width-1 [12:8]
`define FST_CMPC_START_LO 0
`define FST_CMPC_SIZE_LO 8
`define FST_CMPC_SECOND 16
`define FST_CMPC_RESET 32'h001f_001f

`define FST_WINDOW_STEP 4
`define FST_HIGH_LSB 32
`define FST_COUNT_W 56

`endif

// *** inc/fst_pkg.sv ***
// Types shared by the system timer design files
package fst_pkg;

   // Member order follows the register: off is bit 0
   typedef struct packed {
      logic divideByTwo;
      logic suspend;
      logic timerOff;
   } fst_clock_ctrl_t;

   typedef struct packed {
      logic [4:0] sizeMinusOne;
      logic [4:0] startBit;
   } fst_cmp_field_t;

   typedef enum logic [1:0] {
      FST_IDLE,
      FST_DATA
   } fst_bus_state_t;

endpackage

// *** logic/fst_compare_unit.sv ***
// One compare channel of the system timer
`timescale 1ns/1ns
`default_nettype none

module fst_compare_unit
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [55:0] count,
   input wire logic [31:0] compareValue,
   input wire fst_pkg::fst_cmp_field_t field,
   output logic match
);

   wire logic [55:0] shifted;
   wire logic [31:0] fieldMask;
   wire logic equalNow;
   logic equalPrev;

   // Partial counter field selected by start bit and width
   assign shifted = count >> field.startBit;
   assign fieldMask = 32'hffff_ffff >> (5'h1f - field.sizeMinusOne);
   assign equalNow = ((shifted[31:0] ^ compareValue) & fieldMask) == 32'h0000_0000;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         // Seen as equal already, so no false event out of reset
         equalPrev <= 1'b1;
      end
      else
      begin
         equalPrev <= equalNow;
      end
   end

   // Rising edge of equality, so a held count gives one event
   assign match = equalNow && !equalPrev;

endmodule // fst_compare_unit

`default_nettype wire

// *** dv/fst_bus_master.sv ***
// Bus master model standing in for the processor core
`timescale 1ns/1ns
`default_nettype none
`include "fst_regs.svh"

module fst_bus_master
(
   input wire logic clk,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [11:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   initial
   begin
      hsel = 1'b0;
      haddr = 12'h000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
   end

   // Single word transfer, entered just after a rising edge
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      haddr <= ~a;
      htrans <= 2'h0;
      hwdata <= wr ? wd : ~wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
      // Released data no longer shows the last value
      hwdata <= ~hwdata;
   endtask

   // Low window first, then capture, for one consistent value
   task automatic read_full(output logic [55:0] v);
      logic [31:0] lo;
      logic [31:0] hi;
      xfer(1'b0, `FST_OFF_WINDOW_0, 32'h0000_0000, lo);
      xfer(1'b0, `FST_OFF_CAPTURE, 32'h0000_0000, hi);
      v = {hi[23:0], lo};
   endtask
endmodule // fst_bus_master

`default_nettype wire

// *** dv/fst_system_timer_test.sv ***
// Self-checking testbench of the system timer
`timescale 1ns/1ns
`default_nettype none
`include "fst_regs.svh"

module fst_system_timer_test;
   logic clk;
   logic resetn;
   logic appResetReq;
   logic hsel;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [2:0] hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic irq;
   logic serviceRequest0;
   logic serviceRequest1;
   int num_errors = 0;
   int compares = 0;
   logic [31:0] a;
   logic [31:0] b;
   logic [55:0] full;
   logic [31:0] rowCtrl [5] = '{32'h0000_0004, 32'h0000_0000, 32'h0000_0002,
      32'h0000_0001, 32'h0000_0006};
   logic [31:0] rowDelta [5] = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0000,
      32'h0000_0000, 32'h0000_0000};

   fst_system_timer uut (.clk(clk), .resetn(resetn), .appResetReq(appResetReq),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .irq(irq), .serviceRequest0(serviceRequest0),
      .serviceRequest1(serviceRequest1));

   fst_bus_master mst (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ****************************************
   // Helpers
   // ****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic results;
      if (num_errors == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic wr(input logic [11:0] ad, input logic [31:0] d);
      logic [31:0] x;
      mst.xfer(1'b1, ad, d, x);
   endtask

   task automatic rd(input logic [11:0] ad, output logic [31:0] d);
      mst.xfer(1'b0, ad, 32'h0000_0000, d);
   endtask

   task automatic rdchk(input logic [11:0] ad, input logic [31:0] exp);
      logic [31:0] d;
      rd(ad, d);
      check(d, exp);
   endtask

   task automatic wait_pulse(input int ch);
      int i;
      for (i = 0; i < 700; i++)
      begin
         @(negedge clk);
         if ((ch == 0 ? serviceRequest0 : serviceRequest1) === 1'b1)
            break;
      end
      check({31'h0, i < 700}, 32'h0000_0001);
      @(posedge clk);
   endtask

   task automatic irq_after(input logic exp);
      repeat (3) @(negedge clk);
      check({31'h0, irq}, {31'h0, exp});
      @(posedge clk);
   endtask

   task automatic app_pulse;
      @(posedge clk);
      appResetReq <= 1'b1;
      repeat (6) @(posedge clk);
      appResetReq <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   initial
   begin
      #400000;
      num_errors++;
      results();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      resetn = 1'b0;
      appResetReq = 1'b0;
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 5; i++)
      begin
         wr(`FST_OFF_CLOCK_CONTROL, rowCtrl[i]);
         rd(`FST_OFF_WINDOW_0, a);
         rd(`FST_OFF_WINDOW_0, b);
         check(b - a, rowDelta[i]);
      end
      // Timer stands still here: windows against one full value
      mst.read_full(full);
      rdchk(`FST_OFF_WINDOW_6, {8'h00, full[55:32]});
      for (int n = 1; n < 6; n++)
      begin
         rd(`FST_OFF_WINDOW_0 + 12'(4 * n), a);
         check(a, 32'(full >> (4 * n)));
      end
      wr(`FST_OFF_WINDOW_0, 32'hffff_ffff);
      rdchk(`FST_OFF_WINDOW_0, full[31:0]);
      wr(12'h0fc, 32'ha5a5_a5a5);
      rdchk(12'h0fc, 32'h0000_0000);

      // ****************************************
      // Reset in mid-run
      // ****************************************
      resetn <= 1'b0;
      #2;
      check(hrdata, 32'h0000_0000);
      check({27'h0, hreadyout, hresp, irq, serviceRequest0, serviceRequest1}, 32'h0000_0010);
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      rd(`FST_OFF_WINDOW_0, a);
      rd(`FST_OFF_WINDOW_0, b);
      check(b - a, 32'h0000_0001);
      rdchk(`FST_OFF_CLOCK_CONTROL, `FST_CLC_RESET);
      rdchk(`FST_OFF_COMPARE_CONTROL, `FST_CMPC_RESET);
      rdchk(`FST_OFF_IRQ_MASK, 32'h0000_0000);
      rdchk(`FST_OFF_IRQ_STATUS, 32'h0000_0000);

      // ****************************************
      // Compare channels and interrupt
      // ****************************************
      wr(`FST_OFF_CLOCK_CONTROL, 32'h0000_0000);
      wr(`FST_OFF_COMPARE_CONTROL, 32'h0304_0300);
      wr(`FST_OFF_COMPARE_0, 32'h0000_0005);
      wr(`FST_OFF_COMPARE_1, 32'h0000_0002);
      wr(`FST_OFF_IRQ_STATUS, 32'h0000_0003);
      wait_pulse(0);
      irq_after(1'b0);
      rd(`FST_OFF_IRQ_STATUS, a);
      check(a & 32'h1, 32'h0000_0001);
      wr(`FST_OFF_IRQ_MASK, 32'h0000_0001);
      irq_after(1'b1);
      wr(`FST_OFF_CLOCK_CONTROL, 32'h0000_0002);
      wr(`FST_OFF_IRQ_STATUS, 32'h0000_0001);
      irq_after(1'b0);
      rd(`FST_OFF_IRQ_STATUS, a);
      check(a & 32'h1, 32'h0000_0000);
      wr(`FST_OFF_IRQ_MASK, 32'h0000_0002);
      wr(`FST_OFF_CLOCK_CONTROL, 32'h0000_0000);
      wait_pulse(1);
      // Channel one looks at bits 7..4 only, so they still read two
      rd(`FST_OFF_WINDOW_0, a);
      check((a >> 4) & 32'h0000_000f, 32'h0000_0002);
      irq_after(1'b1);

      // ****************************************
      // Application reset
      // ****************************************
      wr(`FST_OFF_APP_RESET, 32'h0000_0001);
      wr(`FST_OFF_IRQ_MASK, 32'h0000_0003);
      rd(`FST_OFF_WINDOW_0, a);
      app_pulse();
      rd(`FST_OFF_WINDOW_0, b);
      check({31'h0, b > a}, 32'h0000_0001);
      rdchk(`FST_OFF_IRQ_MASK, 32'h0000_0003);
      wr(`FST_OFF_APP_RESET, 32'h0000_0000);
      app_pulse();
      rd(`FST_OFF_WINDOW_0, b);
      check({31'h0, b < 32'h0000_0020}, 32'h0000_0001);
      rdchk(`FST_OFF_IRQ_MASK, 32'h0000_0000);
      rdchk(`FST_OFF_CLOCK_CONTROL, 32'h0000_0000);
      rdchk(`FST_OFF_COMPARE_CONTROL, `FST_CMPC_RESET);
      rdchk(`FST_OFF_COMPARE_0, 32'h0000_0000);
      results();
   end
endmodule // fst_system_timer_test

`default_nettype wire
